/* File: hdl/vbap_access_path.v */
// Video board host access path: output alignment, decodes, port, wait control
// Function
// R1: Cursor delayed two character clocks before merging into colour outputs.
// R2: Syncs and three colour lines re-registered together on dot clock.
// R3: Colour outputs high means colour on, low means black.
// R4: Monochrome: three colour bits decoded one-hot into eight registered lines.
// R5: Low address byte decodes controller, output port and light-pen selects.
// R6: Readback select active when controller or port select active.
// R7: Board read buffer enabled for an I/O select or any bank select with data-in strobe.
// R8: Two low address bits pick port register; direction from output status.
// R9: Host programs every port line as an output.
// R10: Display enables gate dot video; flash forces enabled colours high.
// R11: Bank write-selects choose banks; colours written in separate cycles.
// R12: Clear-screen bit drives memory circuits to clear quickly.
// R13: Memory address decoded to red, green and blue 64K bank selects.
// R14: Bank decode only with RAM enable, memory cycle, never I/O output.
// R15: Each bank select covers 64K; only 32K populated.
// R16: Any-bank select formed; with data-in strobe enables read buffer.
// R17: Phantom line asserted whenever any bank select is active.
// R18: Ready driven low while controller owns video RAM.
// R19: Host keeps bank select asserted through the wait.
// R20: Read data driven from the single selected bank latch with strobe.
// R21: Upper address plus latched offset maps host view onto 0-64K.
// R22: Light-pen select only while servicing light-pen interrupt.
// R23: Eight dots per character; character strobe every eighth dot.
// R24: Controller owns two of three slots; host gets third.
// R25: Ready released at start of host slot.
//
// The register offsets and register access over Wishbone were decided locally.
`timescale 1ns/1ps
`include "vbap_consts.vh"
module vbap_access_path #(
    parameter DOTS_PER_CHAR = 8
) (
    input wire mclk,
    input wire rst,
    // Wishbone register slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [3:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output wire wb_ack_o,
    // Video inputs from the display controller
    input wire hsyncIn,
    input wire vsyncIn,
    input wire cursorIn,
    input wire redDot,
    input wire greenDot,
    input wire blueDot,
    // Host bus
    input wire [23:0] busAddr,
    input wire [7:0] busDataOut,
    input wire ioCycle,
    input wire memRead,
    input wire memWrite,
    input wire outCycle,
    input wire dataInStrobe,
    input wire peripheralEnableClock,
    input wire lightPenIrqActive,
    input wire [7:0] redLatch,
    input wire [7:0] greenLatch,
    input wire [7:0] blueLatch,
    input wire [7:0] controllerReadData,
    // Video outputs
    output reg redOut,
    output reg greenOut,
    output reg blueOut,
    output reg hsyncOut,
    output reg vsyncOut,
    output reg [7:0] greyLevel,
    // Decodes and bus control
    output wire displayControllerSelect,
    output wire outputPortSelect,
    output wire controllerPortReadbackSelect,
    output wire lightPenSelect,
    output wire boardIoReadSelect,
    output wire boardReadBufferEnable,
    output wire redBankSelect,
    output wire greenBankSelect,
    output wire blueBankSelect,
    output wire anyBankSelect,
    output wire anyBankSelectBuffered,
    output wire phantom,
    output wire videoRamReady,
    output wire hostAddressPathSelect,
    output reg [7:0] readData,
    output reg [15:0] videoRamAddr,
    output wire [2:0] bankWriteSelect,
    output wire clearScreenRequest,
    output wire clearFillLevel,
    output reg characterStrobe
);
    // ****************************************
    // Character timing and memory slots
    // ****************************************
    reg [2:0] dotCount;
    reg [1:0] slot;
    always @(posedge mclk)
    begin
        if (rst)
        begin
            dotCount <= 3'h0;
            slot <= 2'h0;
            characterStrobe <= 1'b0;
        end
        else
        begin
            characterStrobe <= (dotCount == DOTS_PER_CHAR - 2); // R23
            if (dotCount == DOTS_PER_CHAR - 1)
            begin
                dotCount <= 3'h0;
                if (slot == `VBAP_SLOTS_PER_CYCLE - 1) // R24
                begin
                    slot <= 2'h0;
                end
                else
                begin
                    slot <= slot + 2'h1;
                end
            end
            else
            begin
                dotCount <= dotCount + 3'h1;
            end
        end
    end
    wire hostSlot = (slot == `VBAP_HOST_SLOT); // R24

    // ****************************************
    // Port registers
    // ****************************************
    reg [3:0] displayEnable;
    reg [2:0] writeSelect;
    reg [7:0] mappingOffsetBits;
    reg [2:0] control;
    reg peClkPrev;
    wire wbReq = wb_cyc_i & wb_stb_i;
    reg wbAck;
    wire wbWrite = wbReq & wb_we_i & ~wbAck & wb_sel_i[0];
    wire peFall = peClkPrev & ~peripheralEnableClock;
    wire portWrite = outputPortSelect & outCycle & peFall; // R8
    always @(posedge mclk)
    begin
        if (rst)
        begin
            displayEnable <= 4'h0;
            writeSelect <= 3'h0;
            mappingOffsetBits <= 8'h00;
            control <= 3'h0;
            peClkPrev <= 1'b0;
        end
        else
        begin
            peClkPrev <= peripheralEnableClock;
            if (portWrite)
            begin
                case (busAddr[1:0]) // R8
                    `VBAP_PREG_ENABLE: displayEnable <= busDataOut[3:0];
                    `VBAP_PREG_WRITE: writeSelect <= busDataOut[2:0]; // R11
                    `VBAP_PREG_OFFSET: mappingOffsetBits <= busDataOut;
                    default: control <= busDataOut[2:0];
                endcase
            end
            else if (wbWrite)
            begin
                case (wb_adr_i)
                    `VBAP_WB_ENABLE: displayEnable <= wb_dat_i[3:0];
                    `VBAP_WB_WRITE: writeSelect <= wb_dat_i[2:0];
                    `VBAP_WB_OFFSET: mappingOffsetBits <= wb_dat_i[7:0];
                    `VBAP_WB_CONTROL: control <= wb_dat_i[2:0];
                    default: control <= control;
                endcase
            end
        end
    end
    assign bankWriteSelect = writeSelect; // R11
    assign clearScreenRequest = control[`VBAP_CT_CLEAR]; // R12
    assign clearFillLevel = control[`VBAP_CT_FILL];

    // ****************************************
    // Wishbone slave: one wait state, then ack
    // ****************************************
    always @(posedge mclk)
    begin
        if (rst)
        begin
            wbAck <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end
        else
        begin
            wbAck <= wbReq & ~wbAck;
            case (wb_adr_i)
                `VBAP_WB_ENABLE: wb_dat_o <= {28'h0000000, displayEnable};
                `VBAP_WB_WRITE: wb_dat_o <= {29'h00000000, writeSelect};
                `VBAP_WB_OFFSET: wb_dat_o <= {24'h000000, mappingOffsetBits};
                `VBAP_WB_CONTROL: wb_dat_o <= {28'h0000000, ~videoRamReady, control};
                default: wb_dat_o <= 32'h00000000;
            endcase
        end
    end
    assign wb_ack_o = wbAck;

    // ****************************************
    // I/O decode
    // ****************************************
    wire [7:0] ioAddr = busAddr[7:0];
    assign displayControllerSelect = ioCycle &
        ((ioAddr & `VBAP_IO_CTRL_MASK) == `VBAP_IO_CTRL_BASE); // R5
    assign outputPortSelect = ioCycle &
        ((ioAddr & `VBAP_IO_PORT_MASK) == `VBAP_IO_PORT_BASE); // R5
    // Light-pen counters are only meaningful while an interrupt is serviced
    assign lightPenSelect = ioCycle & lightPenIrqActive &
        ((ioAddr & `VBAP_IO_PEN_MASK) == `VBAP_IO_PEN_BASE); // R22
    assign controllerPortReadbackSelect = displayControllerSelect | outputPortSelect; // R6
    assign boardIoReadSelect = controllerPortReadbackSelect | lightPenSelect;

    // ****************************************
    // Bank select decode
    // ****************************************
    // Full 64K windows decoded; only the low 32K of each is populated
    wire bankDecodeEnable = control[`VBAP_CT_RAMEN] & (memRead | memWrite) & ~outCycle; // R14
    assign redBankSelect = bankDecodeEnable & (busAddr[23:16] == `VBAP_BANK_RED); // R13 R15
    assign greenBankSelect = bankDecodeEnable & (busAddr[23:16] == `VBAP_BANK_GREEN); // R13
    assign blueBankSelect = bankDecodeEnable & (busAddr[23:16] == `VBAP_BANK_BLUE); // R13
    assign anyBankSelect = redBankSelect | greenBankSelect | blueBankSelect; // R16
    assign anyBankSelectBuffered = anyBankSelect;
    assign phantom = anyBankSelect; // R17
    assign boardReadBufferEnable = dataInStrobe & (boardIoReadSelect | anyBankSelect); // R7 R16

    // ****************************************
    // Wait control and address path
    // ****************************************
    // Host relies on holding its bank select through the wait
    assign videoRamReady = ~(anyBankSelect & ~hostSlot); // R18 R25 R19
    assign hostAddressPathSelect = anyBankSelect & hostSlot;

    // ****************************************
    // Read data and address mapping
    // ****************************************
    always @(posedge mclk)
    begin
        if (rst)
        begin
            readData <= 8'h00;
            videoRamAddr <= 16'h0000;
        end
        else
        begin
            videoRamAddr <= {busAddr[15:8] + mappingOffsetBits, busAddr[7:0]}; // R21
            if (dataInStrobe & redBankSelect) // R20
            begin
                readData <= redLatch;
            end
            else if (dataInStrobe & greenBankSelect)
            begin
                readData <= greenLatch;
            end
            else if (dataInStrobe & blueBankSelect)
            begin
                readData <= blueLatch;
            end
            else if (dataInStrobe & controllerPortReadbackSelect)
            begin
                readData <= outputPortSelect ? {4'h0, displayEnable} : controllerReadData;
            end
            else
            begin
                readData <= 8'h00;
            end
        end
    end

    // ****************************************
    // Video output alignment
    // ****************************************
    wire cursorDelayed;
    vbap_delay_line #(
        .WIDTH(1),
        .DEPTH(`VBAP_CURSOR_DELAY)
    ) cursorDelay (
        .mclk(mclk),
        .rst(rst),
        .shift(characterStrobe),
        .din(cursorIn),
        .dout(cursorDelayed)
    ); // R1
    wire flash = displayEnable[`VBAP_EN_FLASH];
    wire [2:0] dots = {blueDot, greenDot, redDot};
    wire [2:0] enables = displayEnable[2:0];
    wire [2:0] colour = enables & (flash ? 3'h7 : dots); // R10
    wire [2:0] merged = colour | {3{cursorDelayed}}; // R1
    always @(posedge mclk)
    begin
        if (rst)
        begin
            redOut <= 1'b0;
            greenOut <= 1'b0;
            blueOut <= 1'b0;
            hsyncOut <= 1'b0;
            vsyncOut <= 1'b0;
            greyLevel <= 8'h01;
        end
        else
        begin
            // All five lines share one register stage to equalise skew
            redOut <= merged[0]; // R2 R3
            greenOut <= merged[1]; // R2 R3
            blueOut <= merged[2]; // R2 R3
            hsyncOut <= hsyncIn; // R2
            vsyncOut <= vsyncIn; // R2
            greyLevel <= 8'h01 << dots; // R4
        end
    end
endmodule // vbap_access_path

/* File: hdl/vbap_consts.vh */
// Constants for the video board CPU access path
`ifndef VBAP_CONSTS_VH
`define VBAP_CONSTS_VH
// ****************************************
// I/O port addresses (low address byte)
// ****************************************
`define VBAP_IO_CTRL_BASE 8'hdc
`define VBAP_IO_CTRL_MASK 8'hfe
`define VBAP_IO_PORT_BASE 8'hd8
`define VBAP_IO_PORT_MASK 8'hfc
`define VBAP_IO_PEN_BASE 8'hde
`define VBAP_IO_PEN_MASK 8'hfe
// ****************************************
// Bank windows (address bits 23:16)
// ****************************************
`define VBAP_BANK_RED 8'h0d
`define VBAP_BANK_GREEN 8'h0e
`define VBAP_BANK_BLUE 8'h0c
// ****************************************
// Port register indices
// ****************************************
`define VBAP_PREG_ENABLE 2'h0
`define VBAP_PREG_WRITE 2'h1
`define VBAP_PREG_OFFSET 2'h2
`define VBAP_PREG_CONTROL 2'h3
// Enable register bits
`define VBAP_EN_RED 0
`define VBAP_EN_GREEN 1
`define VBAP_EN_BLUE 2
`define VBAP_EN_FLASH 3
// Write-select register bits
`define VBAP_WR_RED 0
`define VBAP_WR_GREEN 1
`define VBAP_WR_BLUE 2
// Control register bits
`define VBAP_CT_RAMEN 0
`define VBAP_CT_CLEAR 1
`define VBAP_CT_FILL 2
// ****************************************
// Wishbone register byte addresses
// ****************************************
`define VBAP_WB_ENABLE 4'h0
`define VBAP_WB_WRITE 4'h4
`define VBAP_WB_OFFSET 4'h8
`define VBAP_WB_CONTROL 4'hc
// ****************************************
// Timing
// ****************************************
`define VBAP_CURSOR_DELAY 2
`define VBAP_SLOTS_PER_CYCLE 3
`define VBAP_HOST_SLOT 2'h2
`endif

/* File: hdl/vbap_delay_line.v */
// Small parameterised shift delay line with enable
`timescale 1ns/1ps
module vbap_delay_line #(
    parameter WIDTH = 1,
    parameter DEPTH = 2
) (
    input wire mclk,
    input wire rst,
    input wire shift,
    input wire [WIDTH-1:0] din,
    output wire [WIDTH-1:0] dout
);
    reg [WIDTH*DEPTH-1:0] stages;
    // New word enters at the bottom; one slice covers every depth, including one
    wire [WIDTH*(DEPTH+1)-1:0] chain = {stages, din};
    always @(posedge mclk)
    begin
        if (rst)
        begin
            stages <= {WIDTH*DEPTH{1'b0}};
        end
        else if (shift)
        begin
            stages <= chain[WIDTH*DEPTH-1:0];
        end
    end
    assign dout = stages[WIDTH*DEPTH-1:WIDTH*(DEPTH-1)];
endmodule // vbap_delay_line

/* File: verif/vbap_access_path_tb.sv */
// Self-checking bench for the host access path
`timescale 1ns/1ps
module vbap_access_path_tb;
    logic mclk, rst, wb_cyc_i, wb_stb_i, wb_we_i, hsyncIn, vsyncIn, cursorIn;
    logic redDot, greenDot, blueDot;
    logic [3:0] wb_adr_i, wb_sel_i;
    logic [31:0] wb_dat_i, q;
    logic [7:0] redLatch, greenLatch, blueLatch, controllerReadData;
    wire [31:0] wb_dat_o;
    wire [23:0] busAddr;
    wire [15:0] videoRamAddr;
    wire [7:0] busDataOut, greyLevel, readData;
    wire [2:0] bankWriteSelect;
    wire wb_ack_o, ioCycle, memRead, memWrite, outCycle, dataInStrobe;
    wire peripheralEnableClock, lightPenIrqActive, redOut, greenOut, blueOut;
    wire hsyncOut, vsyncOut, displayControllerSelect, outputPortSelect;
    wire controllerPortReadbackSelect, lightPenSelect, boardIoReadSelect;
    wire boardReadBufferEnable, redBankSelect, greenBankSelect, blueBankSelect;
    wire anyBankSelect, anyBankSelectBuffered, phantom, videoRamReady;
    wire hostAddressPathSelect, clearScreenRequest, clearFillLevel, characterStrobe;
    int fail_count = 0;
    int checks = 0;
    vbap_access_path #(.DOTS_PER_CHAR(8)) dut (.*);
    vbap_host_model host (.*);
    always #12.5 mclk = ~mclk;
    task chk(input [31:0] g, input [31:0] e);
        checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("[ERR] t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task give_verdict;
        if (fail_count == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task wb(input w, input [3:0] a, input [3:0] s, input [31:0] d);
        @(posedge mclk);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= d;
        do @(posedge mclk); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask
    // ****
    // Scenarios
    // ****
    task t_wb;
        wb(1'b1, 4'h0, 4'hf, 32'h0f);
        wb(1'b0, 4'h0, 4'hf, 32'h0);
        chk(q, 32'h0f);
        wb(1'b1, 4'h4, 4'he, 32'h7);
        wb(1'b0, 4'h4, 4'hf, 32'h0);
        chk(q, 32'h0);
        wb(1'b0, 4'h2, 4'hf, 32'h0);
        chk(q, 32'h0);
    endtask
    task t_io;
        logic [7:0] a;
        logic [3:0] e;
        for (int i = 0; i < 10; i++)
        begin
            a = (i == 9) ? 8'hd7 : (i == 8) ? 8'hde : 8'hd8 + i[7:0];
            e = {a[7:1] == 7'h6e, a[7:2] == 6'h36, a[7:1] == 7'h6f && i != 8, 1'b0};
            e[0] = |e[3:1];
            host.go({16'h0, a}, 8'h0, {i != 8, 5'b10001});
            @(negedge mclk);
            chk({displayControllerSelect, outputPortSelect, lightPenSelect,
                boardReadBufferEnable, boardIoReadSelect}, {e, e[0]});
            chk(controllerPortReadbackSelect, e[3] | e[2]);
            @(negedge mclk);
            if (e[3]) chk(readData, controllerReadData);
            if (e[2]) chk(readData, 8'h0f);
            host.drop;
        end
    endtask
    task t_ctl;
        host.port_wr(2'h1, 8'h06);
        @(negedge mclk);
        chk(bankWriteSelect, 3'b110);
        host.port_wr(2'h3, 8'h03);
        @(negedge mclk);
        chk({clearScreenRequest, clearFillLevel}, 2'b10);
        host.port_wr(2'h3, 8'h05);
        @(negedge mclk);
        chk({clearScreenRequest, clearFillLevel}, 2'b01);
    endtask
    task t_mem;
        logic [2:0] es [0:4];
        logic [7:0] ed [0:2];
        int n;
        es = '{3'b001, 3'b100, 3'b010, 3'b000, 3'b000};
        ed = '{blueLatch, redLatch, greenLatch};
        host.port_wr(2'h3, 8'h00);
        host.go(24'h0d1234, 8'h0, 6'b000101);
        @(negedge mclk);
        chk(anyBankSelect, 1'b0);
        host.drop;
        host.port_wr(2'h3, 8'h01);
        host.port_wr(2'h2, 8'h10);
        for (int i = 0; i < 5; i++)
        begin
            host.go({(i == 4) ? 8'h0d : 8'h0c + i[7:0], 16'h3456}, 8'h0,
                (i == 4) ? 6'b001101 : 6'b000101);
            host.grant;
            @(negedge mclk);
            chk({redBankSelect, greenBankSelect, blueBankSelect, phantom,
                anyBankSelectBuffered}, {es[i], |es[i], |es[i]});
            chk(hostAddressPathSelect, videoRamReady & |es[i]);
            if (i < 3) chk({readData, videoRamAddr}, {ed[i], 16'h4456});
            host.drop;
        end
        // Select held over one full three-slot cycle must wait for two slots
        host.go(24'h0e0000, 8'h0, 6'b000101);
        n = 0;
        repeat (24)
        begin
            @(posedge mclk);
            if (videoRamReady !== 1'b1) n++;
        end
        chk(n, 16);
        host.drop;
    endtask
    task t_video;
        int n;
        host.port_wr(2'h0, 8'h05);
        @(posedge mclk);
        {redDot, greenDot, blueDot, hsyncIn, vsyncIn} <= 5'b11011;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        chk({redOut, greenOut, blueOut, hsyncOut, vsyncOut}, 5'b10011);
        host.port_wr(2'h0, 8'h0d);
        @(posedge mclk);
        @(negedge mclk);
        chk({redOut, greenOut, blueOut}, 3'b101);
        host.port_wr(2'h0, 8'h00);
        @(posedge mclk);
        {redDot, greenDot, cursorIn} <= 3'b001;
        n = 0;
        do begin @(posedge mclk); n++; end while (redOut !== 1'b1 && n < 40);
        cursorIn <= 1'b0;
        chk(n >= 10 && n <= 19, 1'b1);
    endtask
    initial
    begin
        mclk = 1'b0;
        rst = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i, hsyncIn, vsyncIn, cursorIn} = 6'h0;
        {redDot, greenDot, blueDot} = 3'h0;
        wb_adr_i = 4'h0;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0;
        redLatch = 8'h3c;
        greenLatch = 8'h5a;
        blueLatch = 8'ha5;
        controllerReadData = 8'h96;
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        @(negedge mclk);
        chk({greyLevel, videoRamReady, hsyncOut, vsyncOut}, {8'h01, 3'b100});
        t_wb;
        t_io;
        t_ctl;
        t_mem;
        t_video;
        give_verdict;
    end
    initial
    begin
        repeat (5000) @(posedge mclk);
        fail_count++;
        give_verdict;
    end
endmodule // vbap_access_path_tb

/* File: verif/vbap_checker.sv */
// Port assertions for the host access path
`timescale 1ns/1ps
module vbap_checker (
    input wire mclk,
    input wire rst,
    input wire redDot,
    input wire greenDot,
    input wire blueDot,
    input wire [23:0] busAddr,
    input wire ioCycle,
    input wire memRead,
    input wire memWrite,
    input wire outCycle,
    input wire dataInStrobe,
    input wire lightPenIrqActive,
    input wire [7:0] greyLevel,
    input wire displayControllerSelect,
    input wire outputPortSelect,
    input wire controllerPortReadbackSelect,
    input wire lightPenSelect,
    input wire boardReadBufferEnable,
    input wire redBankSelect,
    input wire greenBankSelect,
    input wire blueBankSelect,
    input wire anyBankSelect,
    input wire phantom,
    input wire videoRamReady,
    input wire characterStrobe
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    wire rgbSel = redBankSelect || greenBankSelect || blueBankSelect;
    a_phantom_any: assert property (phantom == rgbSel && anyBankSelect == rgbSel)
        else $error("phantom or any-bank select wrong");
    a_readback_or: assert property (
        controllerPortReadbackSelect == (displayControllerSelect || outputPortSelect))
        else $error("readback select wrong");
    a_buffer_enable: assert property (boardReadBufferEnable == (dataInStrobe &&
        (displayControllerSelect || outputPortSelect || lightPenSelect || rgbSel)))
        else $error("read buffer enable wrong");
    a_bank_cycle: assert property (rgbSel |-> (memRead || memWrite) && !outCycle)
        else $error("bank select outside a memory cycle");
    a_bank_window: assert property (rgbSel |-> $onehot({redBankSelect, greenBankSelect,
        blueBankSelect}) && busAddr[23:16] == (redBankSelect ? 8'h0d : greenBankSelect ?
        8'h0e : 8'h0c)) else $error("bank select outside its window");
    a_grey_decode: assert property (!$past(rst) |-> greyLevel ==
        8'h01 << {$past(blueDot), $past(greenDot), $past(redDot)})
        else $error("grey level not the decoded dots");
    a_strobe_period: assert property (characterStrobe |=> !characterStrobe [*7] ##1
        characterStrobe) else $error("character strobe not every eighth dot");
    a_wait_cause: assert property (!videoRamReady |-> anyBankSelect)
        else $error("wait without a bank select");
    a_wait_release: assert property (anyBankSelect && !videoRamReady |->
        ##[1:16] (videoRamReady || !anyBankSelect)) else $error("wait longer than two slots");
    a_pen_gate: assert property (lightPenSelect |-> lightPenIrqActive && ioCycle)
        else $error("light pen select without interrupt");
    c_wait: cover property (!videoRamReady ##[1:16] videoRamReady);
    c_mem_read: cover property (boardReadBufferEnable && rgbSel);
    c_pen: cover property (lightPenSelect);
endmodule // vbap_checker
bind vbap_access_path vbap_checker u_chk (.*);

/* File: verif/vbap_host_model.sv */
// Host bus master model for the board's bus side
`timescale 1ns/1ps
module vbap_host_model (
    input wire mclk,
    input wire videoRamReady,
    output logic [23:0] busAddr,
    output logic [7:0] busDataOut,
    output logic ioCycle,
    output logic outCycle,
    output logic memRead,
    output logic memWrite,
    output logic dataInStrobe,
    output logic peripheralEnableClock,
    output logic lightPenIrqActive
);
    initial
    begin
        busAddr = 24'h0;
        busDataOut = 8'h0;
        {lightPenIrqActive, ioCycle, outCycle, memRead, memWrite, dataInStrobe} = 6'h0;
        peripheralEnableClock = 1'b0;
    end
    // One byte per cycle: colour banks are written one at a time
    task go(input [23:0] a, input [7:0] d, input [5:0] k);
        @(posedge mclk);
        busAddr <= a;
        busDataOut <= d;
        {lightPenIrqActive, ioCycle, outCycle, memRead, memWrite, dataInStrobe} <= k;
    endtask
    // Request stays up until the slot is granted
    task grant;
        do @(posedge mclk); while (videoRamReady !== 1'b1);
    endtask
    // Released address and data lines show the inverse so a stale value cannot pass; cycle and strobe lines drop low
    task drop;
        @(posedge mclk);
        busAddr <= ~busAddr;
        busDataOut <= ~busDataOut;
        {lightPenIrqActive, ioCycle, outCycle, memRead, memWrite, dataInStrobe} <= 6'h0;
    endtask
    // All port lines are outputs, so only data registers are written
    task port_wr(input [1:0] i, input [7:0] d);
        go({16'h0, 6'h36, i}, d, 6'b011000);
        @(posedge mclk) peripheralEnableClock <= 1'b1;
        @(posedge mclk) peripheralEnableClock <= 1'b0;
        drop;
    endtask
endmodule // vbap_host_model
